// >>> pulse_train_capture_pkg.sv
package pulse_train_capture_pkg;

  // Rates of the system clock and of the measurement timebase
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned TICK_HZ = 7_372_800;
  localparam int ACC_W = 26;
  localparam logic [ACC_W-1:0] ACC_CLK = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(TICK_HZ);
  localparam logic [ACC_W-1:0] ACC_RESET = 26'h0000000;

  // Width codes
  localparam int WIDTH_W = 16;
  localparam logic [WIDTH_W-1:0] WIDTH_MIN = 16'h0001;
  localparam logic [WIDTH_W-1:0] WIDTH_TIMEOUT = 16'hFFFF;
  localparam logic [WIDTH_W-1:0] WIDTH_LAST_COUNT = 16'hFFFE;
  localparam logic [WIDTH_W-1:0] COUNT_RESET = 16'h0000;

  // Edge select encoding
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;

  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_MEAS = 2'b11
  } cap_state_e;

  // One stored interval: the level that was measured and its width
  typedef struct packed {
    logic level;
    logic [WIDTH_W-1:0] width;
  } width_entry_s;

  localparam int ENTRY_W = $bits(width_entry_s);

endpackage : pulse_train_capture_pkg

// >>> pulse_train_capture.sv
`timescale 1ns/1ps

module width_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic ov;
    logic [WIDTH-1:0] od;
  } fifo_state_s;

  fifo_state_s r;
  fifo_state_s n;
  logic push;
  logic load;

  always_comb
  begin
    n = r;
    push = in_valid && !r.full;
    // Output word is a register; it refills as soon as it is taken
    load = (r.cnt != '0) && (!r.ov || out_ready);
    if (push)
    begin
      n.mem[r.wp] = in_data;
      n.wp = AW'(r.wp + 1'b1);
    end
    if (load)
    begin
      n.od = r.mem[r.rp];
      n.rp = AW'(r.rp + 1'b1);
      n.ov = 1'b1;
    end
    else if (out_ready)
    begin
      n.ov = 1'b0;
    end
    n.cnt = (AW + 1)'(r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load});
    n.full = (n.cnt == (AW + 1)'(DEPTH));
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= n;
  end

  assign in_ready = !r.full;
  assign out_valid = r.ov;
  assign out_data = r.od;

endmodule : width_fifo

// Fractional divider: on average STEP ticks per MODULUS clocks, so tick
// spacing jitters by one clock but the rate never drifts.
// ACC_W must hold MODULUS + STEP without wrapping.
module tick_divider #(
  parameter int ACC_W = pulse_train_capture_pkg::ACC_W,
  parameter logic [ACC_W-1:0] STEP = pulse_train_capture_pkg::ACC_STEP,
  parameter logic [ACC_W-1:0] MODULUS = pulse_train_capture_pkg::ACC_CLK
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic restart,
  output logic tick
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } div_state_s;

  div_state_s r;
  div_state_s n;
  logic [ACC_W-1:0] sum;

  always_comb
  begin
    n = r;
    sum = r.acc + STEP;
    tick = (sum >= MODULUS);
    if (restart)
      n.acc = ACC_W'(pulse_train_capture_pkg::ACC_RESET);
    else if (tick)
      n.acc = sum - MODULUS;
    else
      n.acc = sum;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= n;
  end

endmodule : tick_divider

// Summary of operation
// [RULE_01] Edge select 0 arms the capture on a falling edge, 1 on a rising edge.
// [RULE_02] Widths are counted in ticks of a 7 372 800 Hz timebase.
// [RULE_03] Stored widths are unsigned 16-bit counts from 1 to 65 535.
// [RULE_04] Nothing is recorded before the start edge, which is awaited forever.
// [RULE_05] A timed-out interval is stored as 65 535.
// [RULE_06] Each timed-out interval alone gets 65 535; others keep their count, except that a count of 0 is stored as 1.
// [RULE_07] High and low intervals alternate in order from the start edge, except that the interval after a timeout keeps its level.
// [RULE_08] Completion is flagged only once the requested count is stored.
// [RULE_09] The requester leaves the timer to this block while it captures.
// [RULE_10] A count reaching 65 535 without an edge times out and restarts.
module pulse_train_capture #(
  parameter int FIFO_DEPTH = pulse_train_capture_pkg::FIFO_DEPTH,
  // Count after which the next tick ends the interval as a timeout
  parameter logic [15:0] LAST_COUNT = pulse_train_capture_pkg::WIDTH_LAST_COUNT
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic start_edge_select,
  input wire logic [15:0] pulse_count,
  input wire logic cap_in,
  output logic busy,
  output logic done,
  output logic overrun,
  output logic width_valid,
  input wire logic width_ready,
  output pulse_train_capture_pkg::width_entry_s width_array
);

  typedef struct packed {
    pulse_train_capture_pkg::cap_state_e st;
    logic edge_sel;
    logic prev;
    logic level;
    logic [15:0] cnt;
    logic [15:0] target;
    logic [15:0] issued;
    logic [15:0] stored;
    logic hv;
    pulse_train_capture_pkg::width_entry_s hd;
    logic busy;
    logic done;
    logic ovr;
  } cap_state_s;

  cap_state_s r;
  cap_state_s n;
  logic tick;
  logic restart;
  logic rise;
  logic fall;
  logic fifo_ready;
  logic emit;
  logic accepted;
  pulse_train_capture_pkg::width_entry_s entry;
  logic [pulse_train_capture_pkg::ENTRY_W-1:0] fifo_out;

  always_comb
  begin
    n = r;
    n.done = 1'b0;
    n.prev = cap_in;
    emit = 1'b0;
    entry = r.hd;
    rise = cap_in && !r.prev;
    fall = !cap_in && r.prev;
    restart = 1'b0;

    // A held entry drains into the FIFO before anything else
    accepted = r.hv && fifo_ready;
    if (accepted)
    begin
      n.hv = 1'b0;
      n.stored = r.stored + 16'h0001;
      if (n.stored == r.target) // [RULE_08]
      begin
        n.st = pulse_train_capture_pkg::ST_IDLE;
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end

    unique case (r.st)
      pulse_train_capture_pkg::ST_IDLE:
      begin
        if (start)
        begin
          n.target = pulse_count;
          n.edge_sel = start_edge_select;
          n.issued = pulse_train_capture_pkg::COUNT_RESET;
          n.stored = pulse_train_capture_pkg::COUNT_RESET;
          n.ovr = 1'b0;
          if (pulse_count == 16'h0000)
            n.done = 1'b1;
          else
          begin
            n.st = pulse_train_capture_pkg::ST_ARM;
            n.busy = 1'b1;
          end
        end
      end
      pulse_train_capture_pkg::ST_ARM:
      begin
        // No timeout here: a start edge that never comes keeps us waiting
        if ((r.edge_sel == pulse_train_capture_pkg::EDGE_RISE) ? rise
            : fall) // [RULE_01] [RULE_04]
        begin
          n.st = pulse_train_capture_pkg::ST_MEAS;
          n.cnt = pulse_train_capture_pkg::COUNT_RESET;
          n.level = cap_in; // [RULE_07]
          // Tick phase starts over at the start edge
          restart = 1'b1;
        end
      end
      pulse_train_capture_pkg::ST_MEAS:
      begin
        if (cap_in != r.prev)
        begin
          emit = 1'b1;
          entry.level = r.level;
          // An edge before the first tick still reports the least width
          entry.width = (r.cnt == pulse_train_capture_pkg::COUNT_RESET) ?
            pulse_train_capture_pkg::WIDTH_MIN : r.cnt; // [RULE_03]
          n.level = cap_in; // [RULE_07]
          n.cnt = pulse_train_capture_pkg::COUNT_RESET;
        end
        else if (tick &&
                 r.cnt == LAST_COUNT) // [RULE_10]
        begin
          emit = 1'b1;
          entry.level = r.level;
          entry.width = pulse_train_capture_pkg::WIDTH_TIMEOUT; // [RULE_05] [RULE_06]
          n.cnt = pulse_train_capture_pkg::COUNT_RESET;
        end
        else if (tick)
        begin
          n.cnt = r.cnt + 16'h0001;
        end
      end
      default:
      begin
        n.st = pulse_train_capture_pkg::ST_IDLE;
        n.busy = 1'b0;
      end
    endcase

    // Intervals beyond the requested count are not recorded
    if (emit && r.issued != r.target)
    begin
      if (n.hv)
        // Previous entry still blocked by a full FIFO: this one is lost
        n.ovr = 1'b1;
      else
      begin
        n.hv = 1'b1;
        n.hd = entry;
        n.issued = r.issued + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '0;
      r.st <= pulse_train_capture_pkg::ST_IDLE;
    end
    else
      r <= n;
  end

  tick_divider #(
    .ACC_W(pulse_train_capture_pkg::ACC_W),
    .STEP(pulse_train_capture_pkg::ACC_STEP),
    .MODULUS(pulse_train_capture_pkg::ACC_CLK)
  ) u_tick ( // [RULE_02]
    .mclk(mclk),
    .arst_n(arst_n),
    .restart(restart),
    .tick(tick)
  );

  width_fifo #(
    .WIDTH(pulse_train_capture_pkg::ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(r.hv),
    .in_ready(fifo_ready),
    .in_data(r.hd),
    .out_valid(width_valid),
    .out_ready(width_ready),
    .out_data(fifo_out)
  );

  assign width_array = pulse_train_capture_pkg::width_entry_s'(fifo_out);
  assign busy = r.busy;
  assign done = r.done;
  assign overrun = r.ovr;

endmodule : pulse_train_capture

// >>> ptc_monitor.sv
`timescale 1ns/1ps
module ptc_monitor (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [15:0] pulse_count,
  input wire logic cap_in,
  input wire logic busy,
  input wire logic done,
  input wire logic width_valid,
  input wire logic width_ready,
  input pulse_train_capture_pkg::width_entry_s width_array
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence s_arm;
    start && !busy && pulse_count != 16'h0000;
  endsequence
  // A quiet pin after arming must leave the output empty
  sequence s_quiet;
    s_arm ##1 $stable(cap_in) [*5];
  endsequence
  a_width_nonzero:
    assert property (width_valid |-> width_array.width != 16'h0000)
    else $error("zero width stored");
  a_word_held:
    assert property (width_valid && !width_ready |=>
      width_valid && $stable(width_array)) else $error("word not held");
  a_quiet_before_edge:
    assert property (s_quiet |-> !width_valid) else $error("early width");
  a_arm_busy:
    assert property (s_arm |=> busy && !done) else $error("not busy");
  a_zero_done:
    assert property (start && !busy && pulse_count == 16'h0000 |=>
      done && !busy) else $error("zero count not done");
  a_done_pulse:
    assert property (done |=> !done) else $error("done too long");
  a_done_idle:
    assert property (done && !start |=> !busy) else $error("busy after done");
  a_busy_fell:
    assert property ($fell(busy) |-> done || $past(done))
    else $error("busy dropped without done");
  a_busy_ignores:
    assert property (busy && start && !done |=> busy || done)
    else $error("start taken while busy");
endmodule : ptc_monitor

bind pulse_train_capture ptc_monitor i_ptc_monitor (.mclk(mclk),
  .arst_n(arst_n), .start(start), .pulse_count(pulse_count),
  .cap_in(cap_in), .busy(busy), .done(done), .width_valid(width_valid),
  .width_ready(width_ready), .width_array(width_array));

// >>> pulse_source.sv
`timescale 1ns/1ps
module pulse_source (
  input wire logic mclk,
  output logic cap_in
);
  initial cap_in = 1'b0;
  // Source only drives the pin, never the capture timer
  task automatic seg(input logic lvl, input int n);
    cap_in <= lvl;
    repeat (n) @(posedge mclk);
  endtask : seg
endmodule : pulse_source

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic sel = 1'b0;
  logic [15:0] cnt = 16'h0000;
  logic width_ready = 1'b1;
  logic busy, done, overrun, width_valid, cap_in;
  pulse_train_capture_pkg::width_entry_s width_array;
  logic [16:0] got[$];
  int error_cnt = 0;
  int tests_run = 0;
  int done_cnt = 0;
  int n_done = 0;
  // Short timeout keeps the timeout scenario within the run's budget
  localparam logic [15:0] T_LAST = 16'h00FE;
  always #10 mclk = ~mclk;
  pulse_train_capture #(.LAST_COUNT(T_LAST)) i_pulse_train_capture (
    .mclk(mclk), .arst_n(arst_n),
    .start(start), .start_edge_select(sel), .pulse_count(cnt),
    .cap_in(cap_in), .busy(busy), .done(done), .overrun(overrun),
    .width_valid(width_valid), .width_ready(width_ready),
    .width_array(width_array));
  pulse_source i_pulse_source (.mclk(mclk), .cap_in(cap_in));
  always @(posedge mclk)
  begin
    if (width_valid && width_ready) got.push_back(width_array);
    if (done) done_cnt++;
  end
  task automatic check(input logic [16:0] s, input logic [16:0] e,
    input int t = 0);
    tests_run++;
    if ($isunknown(s) || s[16] !== e[16] || s[15:0] + t < e[15:0] ||
      s[15:0] > e[15:0] + t)
    begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  // Divider phase is unknown to the bench, hence the slack of two ticks
  function automatic logic [15:0] ticks(input int n);
    return 16'(longint'(n) * pulse_train_capture_pkg::TICK_HZ /
      pulse_train_capture_pkg::CLK_HZ);
  endfunction : ticks
  task automatic go(input logic s, input logic [15:0] n);
    @(posedge mclk);
    start <= 1'b1;
    sel <= s;
    cnt <= n;
    @(posedge mclk);
    start <= 1'b0;
  endtask : go
  task automatic play(input logic l, input int w[$]);
    foreach (w[i]) i_pulse_source.seg(l ^ i[0], w[i]);
    i_pulse_source.seg(l ^ 1'(w.size()), 10);
  endtask : play
  // Also lets a full FIFO drain before the words are counted
  task automatic wait_done(input int n_words);
    n_done++;
    for (int i = 0; i < 2000 && done_cnt < n_done; i++) @(posedge mclk);
    repeat (24) @(posedge mclk);
    check(17'(done_cnt), 17'(n_done));
    check(17'(got.size()), 17'(n_words));
  endtask : wait_done
  task automatic finish_cap(input logic l, input int w[$]);
    wait_done(w.size());
    foreach (w[i])
      if (i < got.size()) check(got[i], {l ^ i[0], ticks(w[i])}, 2);
    got.delete();
  endtask : finish_cap
  task automatic t_rise;
    int w[$] = '{300, 600, 900};
    go(1'b1, 16'h0003);
    i_pulse_source.seg(1'b0, 20);
    check(17'(got.size()), 17'h00000);
    check(17'(busy), 17'h00001);
    go(1'b0, 16'h0000);
    play(1'b1, w);
    finish_cap(1'b1, w);
  endtask : t_rise
  task automatic t_fall;
    int w[$] = '{400, 500};
    go(1'b0, 16'h0002);
    i_pulse_source.seg(1'b1, 200);
    play(1'b0, w);
    finish_cap(1'b0, w);
  endtask : t_fall
  task automatic t_zero;
    int w[$];
    go(1'b1, 16'h0000);
    finish_cap(1'b1, w);
  endtask : t_zero
  task automatic t_fifo;
    int w[$];
    repeat (17) w.push_back(40);
    width_ready <= 1'b0;
    go(1'b1, 16'h0011);
    play(1'b1, w);
    repeat (5) @(posedge mclk);
    check(17'({overrun, width_valid}), 17'h00001);
    width_ready <= 1'b1;
    finish_cap(1'b1, w);
  endtask : t_fifo
  // High level held past the timeout: all-ones entry, then the remainder
  task automatic t_tout;
    int w[$] = '{2000, 300};
    logic [15:0] tmo = pulse_train_capture_pkg::WIDTH_TIMEOUT;
    go(1'b1, 16'h0003);
    play(1'b1, w);
    wait_done(3);
    if (got.size() == 3)
    begin
      check(got[0], {1'b1, tmo});
      check(got[1], {1'b1, ticks(2000) - T_LAST - 16'h0001}, 2);
      check(got[2], {1'b0, ticks(300)}, 2);
    end
    got.delete();
  endtask : t_tout
  task end_of_test;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    t_rise();
    t_fall();
    t_zero();
    t_fifo();
    t_tout();
    end_of_test();
  end
  initial
  begin
    #1000000;
    error_cnt++;
    end_of_test();
  end
endmodule : testbench
